// ===== shared/srsc_pkg.sv
/*
 * Package for the speed ramp and stop control block: register map, field
 * codes, reset values and timing constants.
 * Assumes a 100 MHz APB clock and 32-bit APB data.
 */
package srsc_pkg;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned ENTER_HOLD_MS = 2000;
	localparam int unsigned ENTER_HOLD_CYC = (CLK_HZ / 1000) * ENTER_HOLD_MS;
	localparam int unsigned TICK_US       = 100;
	localparam int unsigned TICK_CYC      = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int unsigned TICKS_PER_DS  = 1000;
	localparam int unsigned SYNC_RESET = 0;

	// -------------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] REG_CHAN   = 8'h00;
	localparam logic [7:0] REG_ACC    = 8'h04;
	localparam logic [7:0] REG_DEC    = 8'h08;
	localparam logic [7:0] REG_SHAPE  = 8'h0c;
	localparam logic [7:0] REG_ASSIGN = 8'h10;
	localparam logic [7:0] REG_ACC2   = 8'h14;
	localparam logic [7:0] REG_DEC2   = 8'h18;
	localparam logic [7:0] REG_STOP   = 8'h1c;
	localparam logic [7:0] REG_REF    = 8'h20;
	localparam logic [7:0] REG_CMD    = 8'h24;
	localparam logic [7:0] REG_STAT   = 8'h28;
	localparam logic [7:0] REG_FREQ   = 8'h2c;

	// -------------------------------------------------------------------
	// Codes and reset values (times in tenths of a second)
	// -------------------------------------------------------------------
	localparam logic [7:0]  SRC_TERM   = 8'h01;
	localparam logic [7:0]  SRC_LOCAL  = 8'h02;
	localparam logic [7:0]  SRC_REMOTE = 8'h03;
	localparam logic [7:0]  SRC_BUS    = 8'h10;
	localparam logic [7:0]  SHAPE_LIN  = 8'h00;
	localparam logic [7:0]  SHAPE_S    = 8'h01;
	localparam logic [7:0]  SHAPE_U    = 8'h02;
	localparam logic [7:0]  STOP_RAMP  = 8'h00;
	localparam logic [7:0]  STOP_DC    = 8'h03;
	localparam logic [7:0]  STOP_FAST  = 8'h08;
	localparam logic [7:0]  STOP_FREE  = 8'h13;
	localparam logic [13:0] TIME_MAX   = 14'd9999;
	localparam logic [13:0] ACC_RST    = 14'd30;
	localparam logic [13:0] DEC_RST    = 14'd30;
	localparam logic [13:0] DEC2_RST   = 14'd50;
	localparam logic [3:0]  DIV_MIN    = 4'h1;
	localparam logic [3:0]  DIV_MAX    = 4'ha;
	localparam logic [3:0]  DIV_RST    = 4'h4;
	localparam logic [15:0] FRS_RST    = 16'd5000;

	// Logic input assignment: 0 none, 1..5 inputs one..four and analog.
	localparam logic [2:0] LI_NONE = 3'h0;

	// Selector field layout of the assignment register.
	localparam int unsigned SW_SEL_LSB   = 0;
	localparam int unsigned SW_POL_BIT   = 3;
	localparam int unsigned FREE_SEL_LSB = 4;
	localparam int unsigned FAST_SEL_LSB = 8;
	localparam int unsigned LOC_SEL_LSB  = 12;
	localparam int unsigned ADAPT_BIT    = 16;

	typedef enum logic [1:0] {
		SRSC_IDLE = 2'b00,
		SRSC_RUN  = 2'b01,
		SRSC_STOP = 2'b10,
		SRSC_WAIT = 2'b11
	} srsc_state_t;

	// Active ramp bundle from which the step for the ramp engine is worked out.
	typedef struct packed {
		logic [13:0] time_ds;
		logic [1:0]  shape;
		logic [3:0]  divider;
		logic        stretch;
	} srsc_ramp_t;

endpackage

// ===== verilog/srsc_sync.sv
/*
 * Two flip-flop synchroniser for a bus of asynchronous pins.
 * Assumes pins are quasi-static relative to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module srsc_sync
	import srsc_pkg::*;
#(
	parameter int W = 6
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	// The first stage feeds only the second, never any logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/srsc_ramp.sv
/*
 * Ramp engine: moves the frequency command toward a target once per tick.
 * Assumes the step and rounding come from the control module.
 */
`timescale 1ns/1ps
`default_nettype none
module srsc_ramp
	import srsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        tick,
	input  wire logic        cut,
	input  wire logic [15:0] target,
	input  wire logic [15:0] step,
	output var  logic [15:0] freq
);
	logic [15:0] freq_nxt;
	logic [16:0] up;

	// ----------------------------------------------------------------
	// Step and clamp
	// ----------------------------------------------------------------
	// Stepping clamps at the target so the output never overshoots.
	always_comb begin
		up       = {1'b0, freq} + {1'b0, step};
		freq_nxt = freq;
		if (cut) begin
			freq_nxt = 16'h0000;
		end else if (tick) begin
			if (freq < target) begin
				freq_nxt = (up >= {1'b0, target}) ? target : up[15:0];
			end else if (freq > target) begin
				freq_nxt = (freq - target <= step) ? target : freq - step;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq <= 16'h0000;
		end else begin
			freq <= freq_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/srsc_top.sv
/*
 * Speed reference ramp and stop sequencing with an APB register file.
 * Assumes logic inputs and keys arrive asynchronously; frequency in 0.01 Hz.
 */
// How it works
// - Combined mode shares one source; separate mode splits command and reference.
// - Channel mode changes only after enter is held two seconds.
// - Command source codes: 01 terminals, 02 local, 03 remote, 10 fieldbus.
// - Separate command selector matters only in separate mode.
// - Assigned forced-local input high gives local control.
// - Acceleration time zero to rated frequency, up to 999.9 s, default 3.0.
// - Deceleration time rated frequency to zero, default 3.0 s.
// - Shape 00 linear, 01 S, 02 U.
// - S shape stretches total ramp to 1.4 times set time.
// - U shape stretches total ramp to 1.5 times set time.
// - Ramp switch input with chosen polarity selects second deceleration.
// - Second acceleration only during PID start and wake-up; the code has no wake-up and uses it only while pid_start_phase is high.
// - Second deceleration, default 5.0 s, used when ramps switched.
// - Second ramp times accessible only when ramp switching assigned.
// - Adaptation on lengthens deceleration to avoid bus overvoltage.
// - Stop type: 00 ramp, 03 DC injection, 08 fast, 13 freewheel.
// - Freewheel by low input or cleared control bit.
// - Restart after freewheel only under level two-wire control.
// - Fast stop input, active low, triggers fast stop.
// - Fast stop divides active deceleration by 1 to 10, default 4.
// - Divider accessible only when fast stop assigned or selected.
`timescale 1ns/1ps
`default_nettype none
module srsc_top
	import srsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        logic_input_one,
	input  wire logic        logic_input_two,
	input  wire logic        logic_input_three,
	input  wire logic        logic_input_four,
	input  wire logic        analog_as_logic_input,
	input  wire logic        enter_key,
	input  wire logic        pid_start_phase,
	input  wire logic        dc_bus_high,
	output var  logic [15:0] freq_cmd,
	output var  logic        dc_inject,
	output var  logic        local_active,
	output var  logic [1:0]  cmd_source
);
	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [7:0] pins_s;
	logic [4:0] li;
	logic       enter_s;
	logic       pid_s;
	logic       dcbus_s;

	srsc_sync #(.W(8)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({dc_bus_high, pid_start_phase, enter_key, analog_as_logic_input,
		            logic_input_four, logic_input_three, logic_input_two,
		            logic_input_one}),
		.dout    (pins_s)
	);
	assign li      = pins_s[4:0];
	assign enter_s = pins_s[5];
	assign pid_s   = pins_s[6];
	assign dcbus_s = pins_s[7];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic        sep_mode_r, sep_mode_nxt;
	logic        sep_pend_r, sep_pend_nxt;
	logic [7:0]  cmd_src_r, cmd_src_nxt;
	logic [7:0]  ref_src_r, ref_src_nxt;
	logic [13:0] acc_r, acc_nxt, dec_r, dec_nxt, acc2_r, acc2_nxt, dec2_r, dec2_nxt;
	logic [7:0]  shape_r, shape_nxt;
	logic [16:0] assign_r, assign_nxt;
	logic [7:0]  stop_r, stop_nxt;
	logic [3:0]  div_r, div_nxt;
	logic [15:0] ref_r, ref_nxt, frs_r, frs_nxt;
	logic [3:0]  ctl_r, ctl_nxt;
	logic [31:0] hold_r, hold_nxt;
	logic [31:0] rdata_nxt;

	wire         wr_en     = psel && penable && pwrite;
	wire         rd_en     = psel && penable && !pwrite;
	wire [2:0]   sw_sel    = assign_r[SW_SEL_LSB +: 3];
	wire         sw_pol    = assign_r[SW_POL_BIT];
	wire [2:0]   free_sel  = assign_r[FREE_SEL_LSB +: 3];
	wire [2:0]   fast_sel  = assign_r[FAST_SEL_LSB +: 3];
	wire [2:0]   loc_sel   = assign_r[LOC_SEL_LSB +: 3];
	wire         adapt_on  = assign_r[ADAPT_BIT];
	wire         sw_assgn  = (sw_sel != LI_NONE);
	wire         div_vis   = (fast_sel != LI_NONE) || (stop_r == STOP_FAST);
	wire         hold_done = (hold_r >= ENTER_HOLD_CYC - 1);

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// Picks the selected logic input; 0 selects nothing.
	function automatic logic pick(input logic [2:0] sel, input logic [4:0] v);
		pick = (sel >= 3'h1 && sel <= 3'h5) ? v[sel - 3'h1] : 1'b0;
	endfunction

	// Register writes; hidden parameters ignore writes while not visible.
	always_comb begin
		sep_mode_nxt = sep_mode_r;
		sep_pend_nxt = sep_pend_r;
		cmd_src_nxt  = cmd_src_r;
		ref_src_nxt  = ref_src_r;
		acc_nxt      = acc_r;
		dec_nxt      = dec_r;
		acc2_nxt     = acc2_r;
		dec2_nxt     = dec2_r;
		shape_nxt    = shape_r;
		assign_nxt   = assign_r;
		stop_nxt     = stop_r;
		div_nxt      = div_r;
		ref_nxt      = ref_r;
		frs_nxt      = frs_r;
		ctl_nxt      = ctl_r;
		hold_nxt     = enter_s ? (hold_done ? hold_r : hold_r + 32'h1) : 32'h0;
		// The mode commits only on the hold completing, so a short press is lost.
		if (enter_s && hold_r == ENTER_HOLD_CYC - 2) begin
			sep_mode_nxt = sep_pend_r;
		end
		if (wr_en) begin
			unique case (paddr)
				REG_CHAN: begin
					sep_pend_nxt = pwdata[0];
					if (sep_mode_r) begin
						cmd_src_nxt = pwdata[15:8];
					end
					ref_src_nxt = pwdata[23:16];
				end
				REG_ACC:    acc_nxt = (pwdata[13:0] > TIME_MAX) ? TIME_MAX : pwdata[13:0];
				REG_DEC:    dec_nxt = (pwdata[13:0] > TIME_MAX) ? TIME_MAX : pwdata[13:0];
				REG_SHAPE:  shape_nxt = pwdata[7:0];
				REG_ASSIGN: assign_nxt = pwdata[16:0];
				REG_ACC2: begin
					if (sw_assgn) begin
						acc2_nxt = (pwdata[13:0] > TIME_MAX) ? TIME_MAX : pwdata[13:0];
					end
				end
				REG_DEC2: begin
					if (sw_assgn) begin
						dec2_nxt = (pwdata[13:0] > TIME_MAX) ? TIME_MAX : pwdata[13:0];
					end
				end
				REG_STOP: begin
					stop_nxt = pwdata[7:0];
					if (div_vis && pwdata[11:8] >= DIV_MIN && pwdata[11:8] <= DIV_MAX) begin
						div_nxt = pwdata[11:8];
					end
				end
				REG_REF: begin
					ref_nxt = pwdata[15:0];
					frs_nxt = (pwdata[31:16] == 16'h0000) ? frs_r : pwdata[31:16];
				end
				REG_CMD:    ctl_nxt = pwdata[3:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sep_mode_r <= 1'b0;
			sep_pend_r <= 1'b0;
			cmd_src_r  <= SRC_TERM;
			ref_src_r  <= SRC_TERM;
			acc_r      <= ACC_RST;
			dec_r      <= DEC_RST;
			acc2_r     <= ACC_RST;
			dec2_r     <= DEC2_RST;
			shape_r    <= SHAPE_LIN;
			assign_r   <= '0;
			stop_r     <= STOP_RAMP;
			div_r      <= DIV_RST;
			ref_r      <= 16'h0000;
			frs_r      <= FRS_RST;
			ctl_r      <= 4'h0;
			hold_r     <= 32'h0;
			prdata     <= 32'h0;
		end else begin
			sep_mode_r <= sep_mode_nxt;
			sep_pend_r <= sep_pend_nxt;
			cmd_src_r  <= cmd_src_nxt;
			ref_src_r  <= ref_src_nxt;
			acc_r      <= acc_nxt;
			dec_r      <= dec_nxt;
			acc2_r     <= acc2_nxt;
			dec2_r     <= dec2_nxt;
			shape_r    <= shape_nxt;
			assign_r   <= assign_nxt;
			stop_r     <= stop_nxt;
			div_r      <= div_nxt;
			ref_r      <= ref_nxt;
			frs_r      <= frs_nxt;
			ctl_r      <= ctl_nxt;
			hold_r     <= hold_nxt;
			prdata     <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Command selection and stop requests
	// ----------------------------------------------------------------
	logic [7:0] eff_src;
	logic       run_cmd, free_req, fast_req, sw_act, loc;
	logic       two_wire_level;

	always_comb begin
		loc     = (loc_sel != LI_NONE) && pick(loc_sel, li);
		// In combined mode the command follows the reference source.
		eff_src = sep_mode_r ? cmd_src_r : ref_src_r;
		if (loc) begin
			eff_src = SRC_LOCAL;
		end
		// Terminals run on input one; displays and fieldbus use the run bit.
		run_cmd  = (eff_src == SRC_TERM) ? li[0] : ctl_r[0];
		two_wire_level = ctl_r[2];
		free_req = ((free_sel != LI_NONE) && !pick(free_sel, li)) || !ctl_r[1];
		fast_req = (fast_sel != LI_NONE) && !pick(fast_sel, li);
		sw_act   = sw_assgn && (pick(sw_sel, li) ^ sw_pol);
		unique case (eff_src)
			SRC_TERM:   cmd_source = 2'b00;
			SRC_LOCAL:  cmd_source = 2'b01;
			SRC_REMOTE: cmd_source = 2'b10;
			SRC_BUS:    cmd_source = 2'b11;
			default:    cmd_source = 2'b00;
		endcase
	end
	assign local_active = loc;

	// ----------------------------------------------------------------
	// Run and stop sequencing
	// ----------------------------------------------------------------
	srsc_state_t st_r, st_nxt;
	logic        run_prev_r;
	logic        fast_act_r, fast_act_nxt;

	always_comb begin
		st_nxt       = st_r;
		fast_act_nxt = fast_act_r;
		unique case (st_r)
			SRSC_IDLE: begin
				if (run_cmd && !run_prev_r && !free_req) begin
					st_nxt       = SRSC_RUN;
					fast_act_nxt = 1'b0;
				end
			end
			SRSC_RUN: begin
				if (free_req) begin
					st_nxt = SRSC_WAIT;
				end else if (fast_req) begin
					st_nxt       = SRSC_STOP;
					fast_act_nxt = 1'b1;
				end else if (!run_cmd) begin
					st_nxt       = (stop_r == STOP_FREE) ? SRSC_WAIT : SRSC_STOP;
					fast_act_nxt = (stop_r == STOP_FAST);
				end
			end
			SRSC_STOP: begin
				if (free_req) begin
					st_nxt = SRSC_WAIT;
				end else if (freq_cmd == 16'h0000) begin
					st_nxt = SRSC_IDLE;
				end
			end
			SRSC_WAIT: begin
				// Two-wire level control may resume; otherwise wait for a new edge.
				if (!free_req && run_cmd && two_wire_level) begin
					st_nxt = SRSC_RUN;
				end else if (!free_req) begin
					st_nxt = SRSC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= SRSC_IDLE;
			run_prev_r <= 1'b1;
			fast_act_r <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			run_prev_r <= run_cmd;
			fast_act_r <= fast_act_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Ramp selection and step
	// ----------------------------------------------------------------
	srsc_ramp_t  rmp;
	logic [15:0] target, step;
	logic [31:0] ticks;
	logic [15:0] tick_cnt_r;
	logic        tick;
	logic        decel;

	// Up to three divides per cycle are costly but keep the step rounded up for any time.
	always_comb begin
		target         = (st_r == SRSC_RUN) ? ref_r : 16'h0000;
		decel          = (target < freq_cmd);
		rmp.shape      = shape_r[1:0];
		rmp.divider    = fast_act_r ? div_r : DIV_MIN;
		rmp.stretch    = adapt_on && dcbus_s && decel;
		rmp.time_ds    = decel ? (sw_act ? dec2_r : dec_r) : (pid_s ? acc2_r : acc_r);
		ticks          = {18'h0, rmp.time_ds} * TICKS_PER_DS;
		unique case (shape_r)
			SHAPE_S: ticks = (ticks * 32'd14) / 32'd10;
			SHAPE_U: ticks = (ticks * 32'd15) / 32'd10;
			default: ticks = ticks;
		endcase
		ticks = ticks / {28'h0, rmp.divider};
		if (rmp.stretch) begin
			ticks = ticks << 1;
		end
		step   = (ticks == 32'h0) ? frs_r : 16'((32'(frs_r) + ticks - 32'h1) / ticks);
		tick   = (tick_cnt_r == 16'(TICK_CYC - 1));
		dc_inject = (st_r == SRSC_STOP) && !fast_act_r && (stop_r == STOP_DC) &&
		            (freq_cmd == 16'h0000);
		rdata_nxt = 32'h0;
		if (rd_en || (psel && !penable)) begin
			unique case (paddr)
				REG_CHAN:   rdata_nxt = {8'h0, ref_src_r, cmd_src_r, 7'h0, sep_mode_r};
				REG_ACC:    rdata_nxt = {18'h0, acc_r};
				REG_DEC:    rdata_nxt = {18'h0, dec_r};
				REG_SHAPE:  rdata_nxt = {24'h0, shape_r};
				REG_ASSIGN: rdata_nxt = {15'h0, assign_r};
				REG_ACC2:   rdata_nxt = sw_assgn ? {18'h0, acc2_r} : 32'h0;
				REG_DEC2:   rdata_nxt = sw_assgn ? {18'h0, dec2_r} : 32'h0;
				REG_STOP:   rdata_nxt = {20'h0, div_vis ? div_r : 4'h0, stop_r};
				REG_REF:    rdata_nxt = {frs_r, ref_r};
				REG_CMD:    rdata_nxt = {28'h0, ctl_r};
				REG_STAT:   rdata_nxt = {24'h0, loc, fast_act_r, free_req, sw_act,
				                         dc_inject, 1'b0, st_r};
				REG_FREQ:   rdata_nxt = {16'h0, freq_cmd};
				default:    rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 16'h0;
		end else begin
			tick_cnt_r <= tick ? 16'h0 : tick_cnt_r + 16'h1;
		end
	end

	srsc_ramp u_ramp (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick),
		.cut     (st_r == SRSC_WAIT || st_r == SRSC_IDLE),
		.target  (target),
		.step    (step),
		.freq    (freq_cmd)
	);
endmodule
`default_nettype wire

// ===== testbench/srsc_far.sv
/*
 * Far-side model: logic input contacts and the operator's enter key.
 * Assumes the bench asks for pin levels on pin_set and enter_set.
 */
`timescale 1ns/1ps
`default_nettype none
module srsc_far
	import srsc_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [4:0] pin_set,
	input  wire logic       enter_set,
	output var  logic [4:0] pins,
	output var  logic       enter_key
);
	// ---------------------------------------------------------------
	// Contacts
	// ---------------------------------------------------------------
	// Levels settle one clock late, so the block never sees a change
	// in the same cycle that the bench asks for it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins      <= 5'h00;
			enter_key <= 1'b0;
		end else begin
			pins      <= pin_set;
			enter_key <= enter_set;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/srsc_top_asserts.sv
/*
 * Checker for srsc_top: APB answers, read data, ramp pacing, stop cut.
 * Assumes it is bound to srsc_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module srsc_top_asserts
	import srsc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        logic_input_one,
	input wire logic        logic_input_two,
	input wire logic        logic_input_three,
	input wire logic        logic_input_four,
	input wire logic        analog_as_logic_input,
	input wire logic [15:0] freq_cmd,
	input wire logic        dc_inject,
	input wire logic        local_active
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Forced local can only follow some pin that was high two edges back.
	logic any_pin;
	assign any_pin = logic_input_one | logic_input_two | logic_input_three
		| logic_input_four | analog_as_logic_input;

	// Access phase, a write that clears the freewheel bit, and eight
	// quiet cycles in which the frequency holds or is zero.
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_cut;
		s_acc ##0 (pwrite && paddr == REG_CMD && !pwdata[1]);
	endsequence
	sequence s_quiet;
		($stable(freq_cmd) || freq_cmd == 16'h0000) [*8];
	endsequence

	AST_PREADY: assert property (pready && !pslverr)
		else $error("APB slave stalled or flagged an error");
	AST_UNMAPPED: assert property (s_acc ##0 (!pwrite && paddr > REG_FREQ) |-> prdata == 32'h0)
		else $error("Unmapped read returned data");
	AST_RD_FREQ: assert property (s_acc ##0 (!pwrite && paddr == REG_FREQ)
		|-> prdata[15:0] == $past(freq_cmd)) else $error("Frequency read mismatch");
	AST_HOLD: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
		else $error("Read data not zero while idle");
	AST_DC_ZERO: assert property (dc_inject |-> freq_cmd == 16'h0000)
		else $error("DC injection with nonzero frequency");
	AST_LOCAL: assert property (local_active |-> $past(any_pin, 2))
		else $error("Local control without a high input");
	AST_CUT: assert property (s_cut |-> ##[1:4] freq_cmd == 16'h0000)
		else $error("Freewheel did not cut the frequency");
	AST_SLEW: assert property ($changed(freq_cmd) && freq_cmd != 16'h0000 |=> s_quiet)
		else $error("Frequency stepped twice within a tick");
endmodule

bind srsc_top srsc_top_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .logic_input_one(logic_input_one),
	.logic_input_two(logic_input_two), .logic_input_three(logic_input_three),
	.logic_input_four(logic_input_four), .analog_as_logic_input(analog_as_logic_input),
	.freq_cmd(freq_cmd), .dc_inject(dc_inject), .local_active(local_active)
);
`default_nettype wire

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for srsc_top: APB master and one task per scenario.
 * Assumes srsc_far drives the pins and the checker is bound to srsc_top.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import srsc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  pin_set = 5'h08;
	logic        enter_set = 1'b0;
	logic [4:0]  pins;
	logic        enter_key;
	logic [15:0] freq_cmd;
	logic        dc_inject;
	logic        local_active;
	logic [1:0]  cmd_source;
	logic [31:0] q;
	int          bad_count = 0;
	int          n_compared = 0;

	// Clock at 100 MHz.
	always #5 pclk = ~pclk;

	srsc_far u_far (.pclk(pclk), .presetn(presetn), .pin_set(pin_set),
		.enter_set(enter_set), .pins(pins), .enter_key(enter_key));

	// The PID phase and bus-voltage inputs stay quiet in every scenario.
	srsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .logic_input_one(pins[0]),
		.logic_input_two(pins[1]), .logic_input_three(pins[2]),
		.logic_input_four(pins[3]), .analog_as_logic_input(pins[4]),
		.enter_key(enter_key), .pid_start_phase(1'h0), .dc_bus_high(1'h0),
		.freq_cmd(freq_cmd), .dc_inject(dc_inject), .local_active(local_active),
		.cmd_source(cmd_source));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; an idle edge follows it.
	task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		int n;
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0, q);
		check(q & m, e);
	endtask

	// Waits a bounded time for the frequency; running out is a mismatch.
	task automatic wait_freq(input logic [15:0] exp, input int lim);
		int n;
		n = 0;
		while (freq_cmd !== exp && n < lim) begin
			@(posedge pclk);
			n++;
		end
		check({16'h0, freq_cmd}, {16'h0, exp});
		if (n >= lim) begin
			give_verdict();
		end
	endtask

	// Restarts the run command with a low-then-high edge on input one.
	task automatic start_run();
		pin_set <= 5'h08;
		wr(REG_CMD, 32'h0000_0002);
		repeat (4) @(posedge pclk);
		pin_set <= 5'h09;
		wr(REG_CMD, 32'h0000_0003);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_vals();
		rd_chk(REG_ACC, 32'hffff_ffff, 32'h0000_001e);
		rd_chk(REG_DEC, 32'hffff_ffff, 32'h0000_001e);
		rd_chk(REG_DEC2, 32'hffff_ffff, 32'h0000_0000);
		rd_chk(REG_STOP, 32'h0000_0fff, 32'h0000_0000);
		rd_chk(REG_REF, 32'hffff_0000, 32'h1388_0000);
		rd_chk(8'h40, 32'hffff_ffff, 32'h0);
		check({31'h0, local_active}, 32'h0);
	endtask

	// A short enter press must not commit separate mode.
	task automatic t_chan();
		rd_chk(REG_CHAN, 32'h0000_ff00, 32'h0000_0100);
		wr(REG_CHAN, 32'h0001_0301);
		enter_set <= 1'b1;
		repeat (100) @(posedge pclk);
		enter_set <= 1'b0;
		repeat (4) @(posedge pclk);
		rd_chk(REG_CHAN, 32'h0000_ff01, 32'h0000_0100);
		check({30'h0, cmd_source}, 32'h0);
	endtask

	task automatic t_ramps2();
		wr(REG_DEC2, 32'h0000_0014);
		wr(REG_ASSIGN, 32'h0000_0001);
		rd_chk(REG_DEC2, 32'hffff_ffff, 32'h0000_0032);
		wr(REG_DEC2, 32'h0000_0014);
		rd_chk(REG_DEC2, 32'hffff_ffff, 32'h0000_0014);
		pin_set <= 5'h09;
		repeat (4) @(posedge pclk);
		rd_chk(REG_STAT, 32'h0000_0010, 32'h0000_0010);
		wr(REG_ASSIGN, 32'h0000_0009);
		rd_chk(REG_STAT, 32'h0000_0010, 32'h0);
		wr(REG_ASSIGN, 32'h0);
		pin_set <= 5'h08;
	endtask

	task automatic t_div();
		logic [31:0] wv [6] = '{32'h0a00, 32'h0008, 32'h0608, 32'h0008, 32'h0b08, 32'h0a08};
		logic [31:0] ev [6] = '{32'h0000, 32'h0408, 32'h0608, 32'h0608, 32'h0608, 32'h0a08};
		for (int i = 0; i < 6; i++) begin
			wr(REG_STOP, wv[i]);
			rd_chk(REG_STOP, 32'h0000_0fff, ev[i]);
		end
		wr(REG_ASSIGN, 32'h0000_0400);
		wr(REG_STOP, 32'h0000_0100);
		rd_chk(REG_STOP, 32'h0000_0fff, 32'h0000_0100);
		wr(REG_ASSIGN, 32'h0);
	endtask

	task automatic t_local();
		wr(REG_ASSIGN, 32'h0000_2000);
		pin_set <= 5'h0a;
		repeat (4) @(posedge pclk);
		check({31'h0, local_active}, 32'h1);
		pin_set <= 5'h08;
		repeat (4) @(posedge pclk);
		check({31'h0, local_active}, 32'h0);
		wr(REG_ASSIGN, 32'h0);
	endtask

	// Step is 5 per tick, so the ramp stops clamped at 7.
	task automatic t_ramp();
		wr(REG_REF, 32'h1388_0007);
		wr(REG_ACC, 32'h0000_0001);
		start_run();
		wait_freq(16'h0007, 40000);
		rd_chk(REG_FREQ, 32'hffff, 32'h7);
		wr(REG_CMD, 32'h0000_0001);
		wait_freq(16'h0000, 8);
		rd_chk(REG_STAT, 32'h0000_0003, 32'h0000_0003);
		wr(REG_CMD, 32'h0000_0003);
		repeat (12000) @(posedge pclk);
		check({16'h0, freq_cmd}, 32'h0);
	endtask

	task automatic t_dc();
		wr(REG_STOP, 32'h0000_0003);
		wr(REG_DEC, 32'h0000_0001);
		start_run();
		wait_freq(16'h0007, 40000);
		pin_set <= 5'h08;
		wr(REG_CMD, 32'h0000_0002);
		check({16'h0, freq_cmd}, 32'h7);
		wait_freq(16'h0000, 40000);
		check({31'h0, dc_inject}, 32'h1);
	endtask

	// Main sequence.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_vals();
		t_chan();
		t_ramps2();
		t_div();
		t_local();
		t_ramp();
		t_dc();
		give_verdict();
	end
endmodule
`default_nettype wire
